//--- src/idm_pkg.sv
// constants for the inter-agent doorbell and mailbox block
// assumes a plain register port with byte addresses relative to the block base
package idm_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_AGENTS = 10;
    localparam int NUM_BUF_AGENTS = 8;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 32;
    localparam int BUF_BYTES = 32;
    localparam int BUF_REGION_BYTES = 4096;
    localparam int BUF_COUNT = 128;
    localparam int BUF_WORDS = BUF_REGION_BYTES / 4;

    // ------------------------------------------------------------------
    // address map: one 64 KB page per agent, page index in addr[19:16]
    // ------------------------------------------------------------------
    localparam logic [3:0] PAGE_CTRL = 4'h0;
    localparam logic [3:0] PAGE_FIRST_AGENT = 4'h1;
    localparam logic [3:0] PAGE_LAST_AGENT = 4'hA;
    localparam logic [3:0] PAGE_MSGBUF = 4'hF;
    localparam logic [15:0] CTRL_APER_OFFSET = 16'h00DC;

    // word index of each agent register within the first 32 bytes
    localparam logic [2:0] REG_SEND = 3'h0;
    localparam logic [2:0] REG_WATCH = 3'h1;
    localparam logic [2:0] REG_PEND = 3'h4;
    localparam logic [2:0] REG_MASK = 3'h5;
    localparam logic [2:0] REG_UNMASK = 3'h6;
    localparam logic [2:0] REG_MASKW = 3'h7;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [NUM_AGENTS-1:0] MASK_RESET = 10'h3FF;
    localparam logic [NUM_AGENTS-1:0] APER_RESET = 10'h000;

    // ------------------------------------------------------------------
    // system interrupt line of each agent, agent index 0 at the right:
    // sequencer, platform, six programmable, bufferless platform,
    // bufferless programmable
    // ------------------------------------------------------------------
    localparam logic [6:0] IRQ_LINE_BASE = 7'h3B;
    localparam logic [NUM_AGENTS-1:0][6:0] IRQ_LINE = {
        7'h44, 7'h3C, 7'h43, 7'h42, 7'h41, 7'h40, 7'h3F, 7'h3E, 7'h3B, 7'h3D
    };

endpackage

//--- src/idm_doorbell.sv
// inter-agent doorbell registers and message buffer store
// assumes the peripheral protection unit has already passed each access,
// and that requester id and security level come from bus logic on core_clk
//
// Behaviour
// - send request bit set raises sender's bit in destination pending flags
// - sent-watch read returns this source's pending bit in every destination
// - sent-watch reports pending only, ignoring destination mask
// - each pending flag bit names one source agent
// - writing one to a pending bit clears it, zero leaves it
// - a cleared pending bit shows at once in the source's sent-watch
// - ten agent register sets, six registers each
// - agent register access screened by per-agent security aperture bit
// - masked pending flags do not drive the interrupt; clearing still works
// - every agent interrupt also driven to the programmable fabric
// - agent interrupts map to system lines 59 to 68
// - eight buffered agents in full mesh; two agents have registers only
// - 32-byte buffers, request and response alternating per source block
// - buffer region is 4 KB holding 128 buffers
// - buffer contents stored uninterpreted, no effect on control
// - agent sets in own 64 KB pages, only first 32 bytes used
// - an agent may signal itself through its own send bit
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/10ps

module idm_doorbell #(
    parameter int NUM_AGENTS = idm_pkg::NUM_AGENTS,
    parameter int NUM_BUF_AGENTS = idm_pkg::NUM_BUF_AGENTS
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [idm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [idm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_secure,
    input wire logic [3:0] reg_requester_id,
    output logic [idm_pkg::DATA_W-1:0] reg_rdata,
    output logic access_error,
    output logic [NUM_AGENTS-1:0] sys_irq,
    output logic [NUM_AGENTS-1:0] fabric_irq
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_AGENTS-1:0][NUM_AGENTS-1:0] pend;
        logic [NUM_AGENTS-1:0] mask;
        logic [NUM_AGENTS-1:0] aper;
        logic [NUM_AGENTS-1:0] irq;
        logic [NUM_AGENTS-1:0] fab;
        logic [idm_pkg::DATA_W-1:0] rdata;
        logic err;
        logic [idm_pkg::BUF_WORDS-1:0][idm_pkg::DATA_W-1:0] mem;
    } idm_state_t;

    idm_state_t state_reg;
    idm_state_t state_next;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic [3:0] page;
    logic [15:0] page_off;
    logic agent_hit;
    logic [3:0] agent_sel;
    logic [2:0] reg_idx;
    logic agent_allowed;
    logic ctrl_hit;
    logic buf_hit;
    logic [2:0] buf_src;
    logic [2:0] buf_dst;
    logic buf_resp;
    logic [9:0] buf_word;
    logic buf_rd_ok;
    logic buf_wr_ok;

    assign page = reg_addr[19:16];
    assign page_off = reg_addr[15:0];
    // only the first 32 bytes of each agent page decode
    assign agent_hit = (page >= idm_pkg::PAGE_FIRST_AGENT) && (page <= idm_pkg::PAGE_LAST_AGENT)
        && (page_off[15:5] == 11'h000);
    assign agent_sel = page - idm_pkg::PAGE_FIRST_AGENT;
    assign reg_idx = page_off[4:2];
    // insecure access passes only where the aperture bit allows it
    assign agent_allowed = agent_hit && (reg_secure || state_reg.aper[agent_sel]);
    assign ctrl_hit = (page == idm_pkg::PAGE_CTRL) && (page_off == idm_pkg::CTRL_APER_OFFSET);

    // 4 KB window: source block 512 bytes, per destination request then response
    assign buf_hit = (page == idm_pkg::PAGE_MSGBUF) && (page_off[15:12] == 4'h0);
    assign buf_src = page_off[11:9];
    assign buf_dst = page_off[8:6];
    assign buf_resp = page_off[5];
    assign buf_word = page_off[11:2];
    // bufferless agents hold ids above the mesh and so never match
    assign buf_rd_ok = buf_hit && ((reg_requester_id == {1'b0, buf_src})
        || (reg_requester_id == {1'b0, buf_dst}));
    assign buf_wr_ok = buf_hit && (buf_resp ? (reg_requester_id == {1'b0, buf_dst})
        : (reg_requester_id == {1'b0, buf_src}));

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [NUM_AGENTS-1:0] wbits;
        logic [NUM_AGENTS-1:0] watch;
        int line;
        wbits = reg_wdata[NUM_AGENTS-1:0];
        watch = '0;
        line = 0;
        state_next = state_reg;
        state_next.err = 1'b0;
        state_next.rdata = '0;

        // sent-watch of the addressed source, pending state only
        for (int d = 0; d < NUM_AGENTS; d++) begin
            watch[d] = state_reg.pend[d][agent_sel];
        end

        if (reg_wr) begin
            if (agent_allowed) begin
                case (reg_idx)
                    idm_pkg::REG_PEND: begin
                        // write one to clear, zero
                        state_next.pend[agent_sel] = state_reg.pend[agent_sel] & ~wbits;
                    end
                    idm_pkg::REG_UNMASK: begin
                        state_next.mask = state_reg.mask & ~wbits;
                    end
                    idm_pkg::REG_MASKW: begin
                        state_next.mask = state_reg.mask | wbits;
                    end
                    default: begin
                    end
                endcase
                // sets applied after clears so a coincident set wins
                if (reg_idx == idm_pkg::REG_SEND) begin
                    for (int d = 0; d < NUM_AGENTS; d++) begin
                        // own bit included, self-signalling allowed
                        if (wbits[d]) begin
                            state_next.pend[d][agent_sel] = 1'b1;
                        end
                    end
                end
                if ((reg_idx != idm_pkg::REG_SEND) && (reg_idx != idm_pkg::REG_PEND)
                    && (reg_idx != idm_pkg::REG_UNMASK) && (reg_idx != idm_pkg::REG_MASKW)) begin
                    state_next.err = 1'b1;
                end
            end else if (ctrl_hit && reg_secure) begin
                state_next.aper = wbits;
            end else if (buf_wr_ok) begin
                // stored as given, never inspected
                state_next.mem[buf_word] = reg_wdata;
            end else begin
                state_next.err = 1'b1;
            end
        end

        if (reg_rd) begin
            if (agent_allowed) begin
                case (reg_idx)
                    idm_pkg::REG_WATCH: begin
                        state_next.rdata[NUM_AGENTS-1:0] = watch;
                    end
                    idm_pkg::REG_PEND: begin
                        state_next.rdata[NUM_AGENTS-1:0] = state_reg.pend[agent_sel];
                    end
                    idm_pkg::REG_MASK: begin
                        state_next.rdata[NUM_AGENTS-1:0] = state_reg.mask;
                    end
                    default: begin
                        // write-only registers read back zero
                        state_next.rdata = '0;
                    end
                endcase
            end else if (ctrl_hit && reg_secure) begin
                state_next.rdata[NUM_AGENTS-1:0] = state_reg.aper;
            end else if (buf_rd_ok) begin
                state_next.rdata = state_reg.mem[buf_word];
            end else begin
                state_next.err = 1'b1;
            end
        end

        // one cycle behind the flags; masking gates only the line
        for (int a = 0; a < NUM_AGENTS; a++) begin
            line = int'(idm_pkg::IRQ_LINE[a]) - int'(idm_pkg::IRQ_LINE_BASE);
            state_next.irq[line] = |(state_reg.pend[a] & ~{NUM_AGENTS{state_reg.mask[a]}});
        end
        // fabric copy kept in its own flops so both fan-outs stay registered
        state_next.fab = state_next.irq;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= '0;
            state_reg.mask <= idm_pkg::MASK_RESET;
            state_reg.aper <= idm_pkg::APER_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign access_error = state_reg.err;
    assign sys_irq = state_reg.irq;
    assign fabric_irq = state_reg.fab;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    logic [NUM_AGENTS-1:0] chk_watch;
    logic [NUM_AGENTS-1:0] chk_line_of;
    always_comb begin
        int ln;
        ln = 0;
        chk_line_of = '0;
        for (int d = 0; d < NUM_AGENTS; d++) begin
            chk_watch[d] = state_reg.pend[d][agent_sel];
        end
        for (int a = 0; a < NUM_AGENTS; a++) begin
            ln = int'(idm_pkg::IRQ_LINE[a]) - int'(idm_pkg::IRQ_LINE_BASE);
            chk_line_of[ln] = |(state_reg.pend[a] & ~{NUM_AGENTS{state_reg.mask[a]}});
        end
    end

    property p_send_sets_pend;
        logic [3:0] s;
        (reg_wr && agent_allowed && reg_idx == idm_pkg::REG_SEND && reg_wdata[0], s = agent_sel)
        |=> state_reg.pend[0][s];
    endproperty
    a_send_sets_pend: assert property (p_send_sets_pend) else $error("send did not set pending");

    property p_watch_read;
        logic [NUM_AGENTS-1:0] w;
        (reg_rd && agent_allowed && reg_idx == idm_pkg::REG_WATCH, w = chk_watch)
        |=> reg_rdata == {{(idm_pkg::DATA_W-NUM_AGENTS){1'b0}}, w};
    endproperty
    a_watch_read: assert property (p_watch_read) else $error("sent-watch read mismatch");

    property p_pend_read;
        logic [NUM_AGENTS-1:0] p;
        (reg_rd && agent_allowed && reg_idx == idm_pkg::REG_PEND, p = state_reg.pend[agent_sel])
        |=> reg_rdata[NUM_AGENTS-1:0] == p;
    endproperty
    a_pend_read: assert property (p_pend_read) else $error("pending read mismatch");

    property p_clear_all;
        logic [3:0] a;
        (reg_wr && agent_allowed && reg_idx == idm_pkg::REG_PEND && &reg_wdata[NUM_AGENTS-1:0],
            a = agent_sel)
        |=> state_reg.pend[a] == '0;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("pending not cleared");

    property p_zero_keeps;
        reg_wr && agent_allowed && reg_idx == idm_pkg::REG_PEND && reg_wdata == '0
        |=> $stable(state_reg.pend);
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed pending");

    property p_clear_seen;
        logic [3:0] a;
        (reg_wr && agent_allowed && reg_idx == idm_pkg::REG_PEND && reg_wdata[0], a = agent_sel)
        |=> !state_reg.pend[a][0];
    endproperty
    a_clear_seen: assert property (p_clear_seen) else $error("watch still shows cleared bit");

    property p_irq_follows;
        1'b1 |=> sys_irq == $past(chk_line_of);
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("interrupt line wrong");

    property p_fabric_copy;
        sys_irq == fabric_irq;
    endproperty
    a_fabric_copy: assert property (p_fabric_copy) else $error("fabric line differs");

    property p_insecure_denied;
        reg_wr && agent_hit && !reg_secure && !state_reg.aper[agent_sel]
        |=> access_error && $stable(state_reg.pend) && $stable(state_reg.mask);
    endproperty
    a_insecure_denied: assert property (p_insecure_denied) else $error("insecure write passed");

    property p_buf_store;
        logic [9:0] w;
        logic [idm_pkg::DATA_W-1:0] v;
        (reg_wr && !agent_hit && !ctrl_hit && buf_wr_ok, w = buf_word, v = reg_wdata)
        |=> state_reg.mem[w] == v && $stable(state_reg.pend);
    endproperty
    a_buf_store: assert property (p_buf_store) else $error("buffer word not stored");

    property p_buf_foreign;
        reg_wr && buf_hit && !buf_wr_ok |=> access_error && $stable(state_reg.mem);
    endproperty
    a_buf_foreign: assert property (p_buf_foreign) else $error("foreign buffer write passed");

    property p_unmask_clears;
        logic [NUM_AGENTS-1:0] b;
        (reg_wr && agent_allowed && reg_idx == idm_pkg::REG_UNMASK,
            b = reg_wdata[NUM_AGENTS-1:0])
        |=> (state_reg.mask & b) == '0;
    endproperty
    a_unmask_clears: assert property (p_unmask_clears) else $error("mask not cleared");

    property p_mask_sets;
        logic [NUM_AGENTS-1:0] b;
        (reg_wr && agent_allowed && reg_idx == idm_pkg::REG_MASKW,
            b = reg_wdata[NUM_AGENTS-1:0])
        |=> (state_reg.mask & b) == b;
    endproperty
    a_mask_sets: assert property (p_mask_sets) else $error("mask not set");

    property p_aper_write;
        logic [NUM_AGENTS-1:0] b;
        (reg_wr && ctrl_hit && reg_secure, b = reg_wdata[NUM_AGENTS-1:0])
        |=> state_reg.aper == b;
    endproperty
    a_aper_write: assert property (p_aper_write) else $error("aperture not written");

    // the aperture must never open from the insecure side
    property p_aper_guarded;
        reg_wr && ctrl_hit && !reg_secure |=> access_error && $stable(state_reg.aper);
    endproperty
    a_aper_guarded: assert property (p_aper_guarded) else $error("aperture opened");

    // only a send may raise a pending flag; buffer traffic never does
    property p_no_stray_set;
        !(reg_wr && agent_allowed && reg_idx == idm_pkg::REG_SEND)
        |=> (state_reg.pend & ~$past(state_reg.pend)) == '0;
    endproperty
    a_no_stray_set: assert property (p_no_stray_set) else $error("stray pending set");

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

    c_send_then_irq: cover property (
        reg_wr && agent_allowed && reg_idx == idm_pkg::REG_SEND ##[1:4] |sys_irq);
    c_clear_after_send: cover property (
        reg_wr && reg_idx == idm_pkg::REG_SEND ##[1:20] reg_wr && reg_idx == idm_pkg::REG_PEND);
    c_buf_roundtrip: cover property (
        reg_wr && buf_wr_ok ##[1:20] reg_rd && buf_rd_ok);
    c_denied: cover property (access_error);

endmodule

//--- tb/idm_agent_model.sv
// processor agent model: issues register and buffer accesses on the plain port
// assumes the testbench calls access() one at a time on core_clk
`timescale 1ns/10ps

module idm_agent_model (
    input wire logic core_clk,
    output logic [idm_pkg::ADDR_W-1:0] reg_addr,
    output logic [idm_pkg::DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic reg_secure,
    output logic [3:0] reg_requester_id,
    input wire logic [idm_pkg::DATA_W-1:0] reg_rdata,
    input wire logic access_error
);
    initial begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_secure = 1'b0;
        reg_requester_id = 4'h0;
    end

    // --------------------------------------------------------------
    // one strobe cycle, answer taken one cycle later
    // --------------------------------------------------------------
    // strobes drop to zero and the other released lines are inverted so stale values never look valid;
    // routing and masking of the lines is left to the caller
    task automatic access(input logic wr, input logic [19:0] addr, input logic [31:0] data,
            input logic sec, input logic [3:0] rid, output logic [31:0] rdata,
            output logic err);
        @(posedge core_clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= addr;
        reg_wdata <= data;
        reg_secure <= sec;
        reg_requester_id <= rid;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
        reg_secure <= ~sec;
        reg_requester_id <= ~rid;
        #1;
        rdata = reg_rdata;
        err = access_error;
    endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the doorbell and mailbox block
// assumes the agent model as sole bus master and a 100 MHz core_clk
`timescale 1ns/10ps

module testbench;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [19:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic reg_secure;
    logic [3:0] reg_requester_id;
    logic [31:0] reg_rdata;
    logic access_error;
    logic [9:0] sys_irq;
    logic [9:0] fabric_irq;
    logic [31:0] rdv;
    logic errv;
    logic sec_v = 1'b1;
    logic [3:0] rid_v = 4'h0;
    int err_count = 0;
    int check_count = 0;
    int d;

    always #5 core_clk = ~core_clk;

    idm_doorbell i_idm_doorbell (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_secure(reg_secure),
        .reg_requester_id(reg_requester_id), .reg_rdata(reg_rdata),
        .access_error(access_error), .sys_irq(sys_irq), .fabric_irq(fabric_irq));

    idm_agent_model i_idm_agent_model (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_secure(reg_secure),
        .reg_requester_id(reg_requester_id), .reg_rdata(reg_rdata),
        .access_error(access_error));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] v);
        i_idm_agent_model.access(1'b1, a, v, sec_v, rid_v, rdv, errv);
    endtask

    task automatic rd(input logic [19:0] a);
        i_idm_agent_model.access(1'b0, a, 32'h0, sec_v, rid_v, rdv, errv);
    endtask

    // interrupt outputs lag the cause by two edges
    task automatic irq_is(input logic [9:0] exp);
        @(posedge core_clk);
        #1;
        check("sys_irq", sys_irq, exp);
        check("fabric_irq", fabric_irq, exp);
    endtask

    function automatic logic [19:0] ar(input int a, input logic [7:0] off);
        return {4'(a + 1), 8'h00, off};
    endfunction

    function automatic logic [19:0] bufa(input int s, input int t, input int r, input int w);
        return {4'hF, 16'(s * 512 + t * 64 + r * 32 + w * 4)};
    endfunction

    function automatic logic [9:0] lb(input int a);
        return 10'h001 << (idm_pkg::IRQ_LINE[a] - idm_pkg::IRQ_LINE_BASE);
    endfunction

    // --------------------------------------------------------------
    // watchdog: whole run is under 300 cycles
    // --------------------------------------------------------------
    initial begin
        #100000;
        check("watchdog", 32'h1, 32'h0);
        tally_and_finish();
    end

    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        rd(ar(0, 8'h14));
        check("mask reset", rdv, 32'(idm_pkg::MASK_RESET));
        irq_is(10'h000);
        for (int a = 0; a < 10; a++) wr(ar(a, 8'h18), 32'h3FF);
        rd(ar(7, 8'h14));
        check("mask open", rdv, 32'h0);
        for (int s = 0; s < 10; s++) begin
            d = (s + 1) % 10;
            wr(ar(s, 8'h00), 32'h1 << d);
            irq_is(lb(d));
            rd(ar(d, 8'h10));
            check("pending", rdv, 32'h1 << s);
            rd(ar(s, 8'h04));
            check("watch", rdv, 32'h1 << d);
            wr(ar(d, 8'h10), ~(32'h1 << s));
            rd(ar(d, 8'h10));
            check("pending kept", rdv, 32'h1 << s);
            wr(ar(d, 8'h10), 32'h1 << s);
            rd(ar(s, 8'h04));
            check("watch cleared", rdv, 32'h0);
            irq_is(10'h000);
        end
        // self signalling, then masking with the flag still pending
        wr(ar(4, 8'h00), 32'h10);
        irq_is(lb(4));
        wr(ar(4, 8'h1C), 32'h3FF);
        irq_is(10'h000);
        rd(ar(4, 8'h04));
        check("watch masked", rdv, 32'h10);
        wr(ar(4, 8'h18), 32'h3FF);
        irq_is(lb(4));
        wr(ar(4, 8'h1C), 32'h3FF);
        wr(ar(4, 8'h10), 32'h10);
        rd(ar(4, 8'h10));
        check("masked clear", rdv, 32'h0);
        wr(ar(4, 8'h18), 32'h3FF);
        irq_is(10'h000);
        // security aperture screening
        sec_v = 1'b0;
        rd(ar(2, 8'h10));
        check("insecure read err", 32'(errv), 32'h1);
        check("insecure read data", rdv, 32'h0);
        wr(ar(2, 8'h00), 32'h8);
        check("insecure write err", 32'(errv), 32'h1);
        sec_v = 1'b1;
        rd(ar(3, 8'h10));
        check("refused send", rdv, 32'h0);
        wr({4'h0, idm_pkg::CTRL_APER_OFFSET}, 32'h4);
        sec_v = 1'b0;
        wr(ar(2, 8'h00), 32'h8);
        check("open write err", 32'(errv), 32'h0);
        wr({4'h0, idm_pkg::CTRL_APER_OFFSET}, 32'h3FF);
        check("insecure aperture write", 32'(errv), 32'h1);
        sec_v = 1'b1;
        rd({4'h0, idm_pkg::CTRL_APER_OFFSET});
        check("aperture", rdv, 32'h4);
        rd(ar(3, 8'h10));
        check("opened send", rdv, 32'h4);
        wr(ar(3, 8'h10), 32'h4);
        // holes in the map
        rd(ar(0, 8'h20));
        check("past 32 bytes", 32'(errv), 32'h1);
        rd(20'hB0000);
        check("reserved page", 32'(errv), 32'h1);
        wr(ar(9, 8'h08), 32'h1);
        check("hole write", 32'(errv), 32'h1);
        rd(ar(9, 8'h08));
        check("hole read", {rdv[30:0], errv}, 32'h0);
        // message buffers
        rid_v = 4'h1;
        wr(bufa(1, 3, 0, 0), 32'hA5A5_0001);
        check("src req wr", 32'(errv), 32'h0);
        rid_v = 4'h3;
        wr(bufa(1, 3, 0, 0), 32'h0000_0001);
        check("dst req wr", 32'(errv), 32'h1);
        wr(bufa(1, 3, 1, 7), 32'h5A5A_0002);
        rd(bufa(1, 3, 0, 0));
        check("dst req rd", rdv, 32'hA5A5_0001);
        rid_v = 4'h1;
        wr(bufa(1, 3, 1, 7), 32'h0000_0003);
        check("src resp wr", 32'(errv), 32'h1);
        rd(bufa(1, 3, 1, 7));
        check("src resp rd", rdv, 32'h5A5A_0002);
        rid_v = 4'h5;
        rd(bufa(1, 3, 0, 0));
        check("third party rd", 32'(errv), 32'h1);
        rid_v = 4'h7;
        wr(bufa(7, 7, 1, 7), 32'hFFFF_FFFF);
        rd(bufa(7, 7, 1, 7));
        check("last buffer word", rdv, 32'hFFFF_FFFF);
        irq_is(10'h000);
        // mid-run reset must drop a live interrupt and return flags, masks and buffers to reset values
        wr(ar(1, 8'h00), 32'h1);
        irq_is(lb(0));
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        irq_is(10'h000);
        rd(ar(0, 8'h14));
        check("mask after reset", rdv, 32'(idm_pkg::MASK_RESET));
        rd(ar(0, 8'h10));
        check("pending after reset", rdv, 32'h0);
        rd({4'h0, idm_pkg::CTRL_APER_OFFSET});
        check("aperture after reset", rdv, 32'(idm_pkg::APER_RESET));
        rd(bufa(7, 7, 1, 7));
        check("buffer after reset", rdv, 32'h0);
        tally_and_finish();
    end
endmodule
